/* design/lfb_consts.svh */
`ifndef LFB_CONSTS_SVH
`define LFB_CONSTS_SVH

// register indices; byte address is four times the index
`define LFB_IDX_RX_BYTE     8'h28
`define LFB_IDX_RX_MATCH1   8'h29
`define LFB_IDX_RX_MATCH2   8'h2A
`define LFB_IDX_TX_BYTE     8'h7E
`define LFB_IDX_CTRL        8'h80
`define LFB_IDX_STATUS      8'h81
`define LFB_IDX_MASK        8'h82

// control register fields
`define LFB_CTRL_DESTUFF    0
`define LFB_CTRL_STUFF      1
`define LFB_CTRL_MF_LOAD    2
`define LFB_CTRL_FS_SRC     3
`define LFB_CTRL_W          4

// status and mask fields
`define LFB_ST_MATCH        0
`define LFB_ST_TX_EMPTY     1
`define LFB_ST_RX_FULL      2
`define LFB_ST_W            3

// reset values
`define LFB_RST_BYTE        8'h00
`define LFB_RST_CTRL        4'h0
`define LFB_RST_FLAGS       3'h0

// stuffing run lengths
`define LFB_STUFF_RUN       3'h5
`define LFB_ONES_SAT        3'h6

// one link byte spans 8 frames of 250 us
`define LFB_BYTE_PERIOD_US  2000
`define LFB_CLK_MHZ         200

`endif

/* design/lfb_pkg.sv */
package lfb_pkg;
    typedef logic [7:0] lfb_byte_t;
    typedef logic [2:0] lfb_cnt_t;
    typedef enum logic [2:0] {
        LFB_TX_LOAD = 3'b001,
        LFB_TX_SEND = 3'b010,
        LFB_TX_WAIT = 3'b100
    } lfb_tx_state_e;
endpackage

/* design/lfb_link_shifter.sv */
// The APB slave port was decided locally.
`timescale 1ns/10ps
`include "lfb_consts.svh"

// Notes on behaviour
// - shift received link bits into 8-bit byte
// - full byte sets full flag, masked interrupt
// - byte equal to a match sets match flag
// - destuff drops zero after five ones
// - zero after six or more ones kept
// - first received bit lands in LSB
// - transmit byte sent LSB first
// - eight bits sent sets empty flag, interrupt
// - unchanged transmit byte is resent
// - stuff zero after five transmitted ones
// - multiframe load and Fs source select
// - receive shifter runs beside packet controller
// - Fs message fields use same registers
module lfb_link_shifter #(
    parameter int BYTE_PERIOD_CYC = `LFB_BYTE_PERIOD_US * `LFB_CLK_MHZ
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit,
    input  wire logic        tx_bit_req,
    input  wire logic        tx_mf_boundary,
    output logic             tx_bit,
    output logic             tx_fs_from_shifter,
    output logic             int_n
);

    initial begin
        if (BYTE_PERIOD_CYC < 8) begin
            $error("byte period too short for eight link bits");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    lfb_pkg::lfb_byte_t           rx_byte_q;
    lfb_pkg::lfb_byte_t           match1_q;
    lfb_pkg::lfb_byte_t           match2_q;
    lfb_pkg::lfb_byte_t           tx_hold_q;
    logic [`LFB_CTRL_W-1:0]       ctrl_q;
    logic [`LFB_ST_W-1:0]         status_q;
    logic [`LFB_ST_W-1:0]         status_d;
    logic [`LFB_ST_W-1:0]         mask_q;
    logic [`LFB_ST_W-1:0]         flag_set;
    logic [`LFB_ST_W-1:0]         flag_clr;
    logic [31:0]                  prdata_q;
    logic                         wr_en;
    logic                         addr_ok;
    logic [7:0]                   reg_idx;

    function automatic logic idx_mapped(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        return (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
               (i == `LFB_IDX_RX_BYTE || i == `LFB_IDX_RX_MATCH1 ||
                i == `LFB_IDX_RX_MATCH2 || i == `LFB_IDX_TX_BYTE ||
                i == `LFB_IDX_CTRL || i == `LFB_IDX_STATUS || i == `LFB_IDX_MASK);
    endfunction

    assign reg_idx = paddr[9:2];
    assign addr_ok = idx_mapped(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en   = psel & penable & pwrite & addr_ok;
    assign prdata  = prdata_q;

    // read data is taken in the setup cycle so the access phase has no wait state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite & ~addr_ok) begin
            // refused reads return zero rather than a neighbouring register
            prdata_q <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            case (reg_idx)
                `LFB_IDX_RX_BYTE:   prdata_q <= {24'h00_0000, rx_byte_q};
                `LFB_IDX_RX_MATCH1: prdata_q <= {24'h00_0000, match1_q};
                `LFB_IDX_RX_MATCH2: prdata_q <= {24'h00_0000, match2_q};
                `LFB_IDX_TX_BYTE:   prdata_q <= {24'h00_0000, tx_hold_q};
                `LFB_IDX_CTRL:      prdata_q <= {28'h000_0000, ctrl_q};
                `LFB_IDX_STATUS:    prdata_q <= {29'h0000_0000, status_q};
                `LFB_IDX_MASK:      prdata_q <= {29'h0000_0000, mask_q};
                default:            prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            match1_q <= `LFB_RST_BYTE;
            match2_q <= `LFB_RST_BYTE;
            ctrl_q   <= `LFB_RST_CTRL;
            mask_q   <= `LFB_RST_FLAGS;
        end else if (wr_en) begin
            case (reg_idx)
                `LFB_IDX_RX_MATCH1: match1_q <= pwdata[7:0];
                `LFB_IDX_RX_MATCH2: match2_q <= pwdata[7:0];
                `LFB_IDX_CTRL:      ctrl_q   <= pwdata[`LFB_CTRL_W-1:0];
                `LFB_IDX_MASK:      mask_q   <= pwdata[`LFB_ST_W-1:0];
                default:            ;
            endcase
        end
    end

    // host copy of the transmit byte; it is only sampled by the shifter
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_hold_q <= `LFB_RST_BYTE;
        end else if (wr_en && reg_idx == `LFB_IDX_TX_BYTE) begin
            tx_hold_q <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status, mask and interrupt

    assign flag_clr = (wr_en && reg_idx == `LFB_IDX_STATUS) ? pwdata[`LFB_ST_W-1:0]
                                                            : `LFB_RST_FLAGS;
    // a new event in the clearing cycle wins over the clear
    assign status_d = (status_q & ~flag_clr) | flag_set;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_q <= `LFB_RST_FLAGS;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            int_n <= 1'b1;
        end else begin
            int_n <= ~|(status_d & mask_q);
        end
    end

    assign tx_fs_from_shifter = ~ctrl_q[`LFB_CTRL_FS_SRC];

    ////////////////////////////////////////////////////////////////////////////
    // receive shifter, runs independent of any other link consumer

    lfb_pkg::lfb_byte_t rx_shift_q;
    lfb_pkg::lfb_cnt_t  rx_cnt_q;
    lfb_pkg::lfb_cnt_t  rx_ones_q;
    logic               rx_drop;
    logic               rx_take;
    logic               rx_done;
    lfb_pkg::lfb_byte_t rx_new;

    function automatic lfb_pkg::lfb_cnt_t ones_next(input lfb_pkg::lfb_cnt_t c,
                                                   input logic b);
        if (!b) begin
            return 3'h0;
        end
        return (c == `LFB_ONES_SAT) ? c : c + 3'h1;
    endfunction

    // only exactly five ones then a zero is a stuffed zero; six or more is a flag
    assign rx_drop = ctrl_q[`LFB_CTRL_DESTUFF] & ~rx_bit &
                     (rx_ones_q == `LFB_STUFF_RUN);
    assign rx_take = rx_bit_valid & ~rx_drop;
    assign rx_done = rx_take & (rx_cnt_q == 3'h7);
    assign rx_new  = {rx_bit, rx_shift_q[7:1]};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_shift_q <= `LFB_RST_BYTE;
            rx_cnt_q   <= 3'h0;
            rx_ones_q  <= 3'h0;
        end else if (rx_bit_valid) begin
            rx_ones_q <= ones_next(rx_ones_q, rx_bit);
            if (rx_take) begin
                rx_shift_q <= rx_new;
                rx_cnt_q   <= rx_cnt_q + 3'h1;
            end
        end
    end

    // an unread byte is simply overwritten by the next one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_byte_q <= `LFB_RST_BYTE;
        end else if (rx_done) begin
            rx_byte_q <= rx_new;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit shifter

    lfb_pkg::lfb_tx_state_e tx_state_q;
    lfb_pkg::lfb_byte_t     tx_shift_q;
    lfb_pkg::lfb_cnt_t      tx_cnt_q;
    lfb_pkg::lfb_cnt_t      tx_ones_q;
    logic                   tx_stuff;
    logic                   tx_last;

    assign tx_stuff = ctrl_q[`LFB_CTRL_STUFF] & (tx_ones_q == `LFB_STUFF_RUN);
    assign tx_last  = tx_bit_req & ~tx_stuff & (tx_state_q == lfb_pkg::LFB_TX_SEND) &
                      (tx_cnt_q == 3'h7);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_state_q <= lfb_pkg::LFB_TX_LOAD;
            tx_shift_q <= `LFB_RST_BYTE;
            tx_cnt_q   <= 3'h0;
            tx_ones_q  <= 3'h0;
            tx_bit     <= 1'b0;
        end else begin
            case (tx_state_q)
                lfb_pkg::LFB_TX_LOAD: begin
                    // old byte is reloaded if the host has not written a new one
                    tx_shift_q <= tx_hold_q;
                    tx_cnt_q   <= 3'h0;
                    tx_state_q <= lfb_pkg::LFB_TX_SEND;
                end
                lfb_pkg::LFB_TX_SEND: begin
                    if (tx_bit_req) begin
                        if (tx_stuff) begin
                            tx_bit    <= 1'b0;
                            tx_ones_q <= 3'h0;
                        end else begin
                            tx_bit     <= tx_shift_q[0];
                            tx_ones_q  <= ones_next(tx_ones_q, tx_shift_q[0]);
                            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                            tx_cnt_q   <= tx_cnt_q + 3'h1;
                            if (tx_cnt_q == 3'h7) begin
                                tx_state_q <= ctrl_q[`LFB_CTRL_MF_LOAD]
                                              ? lfb_pkg::LFB_TX_WAIT
                                              : lfb_pkg::LFB_TX_LOAD;
                            end
                        end
                    end
                end
                lfb_pkg::LFB_TX_WAIT: begin
                    // keeps the Fs pattern aligned to the multiframe
                    if (tx_mf_boundary) begin
                        tx_state_q <= lfb_pkg::LFB_TX_LOAD;
                    end else if (!ctrl_q[`LFB_CTRL_MF_LOAD]) begin
                        tx_state_q <= lfb_pkg::LFB_TX_LOAD;
                    end
                end
                default: begin
                    tx_state_q <= lfb_pkg::LFB_TX_LOAD;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event sources

    always_comb begin
        flag_set                   = `LFB_RST_FLAGS;
        flag_set[`LFB_ST_RX_FULL]  = rx_done;
        flag_set[`LFB_ST_MATCH]    = rx_done &
                                     ((rx_new == match1_q) | (rx_new == match2_q));
        flag_set[`LFB_ST_TX_EMPTY] = tx_last;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_rx_full_set: assert property (@(posedge ref_clk) disable iff (rst)
        rx_done |=> status_q[`LFB_ST_RX_FULL])
        else $error("receive full flag missing after eighth bit");

    a_rx_stuffed_drop: assert property (@(posedge ref_clk) disable iff (rst)
        (rx_bit_valid && !rx_bit && ctrl_q[`LFB_CTRL_DESTUFF] && rx_ones_q == 3'h5)
        |=> $stable(rx_cnt_q) && $stable(rx_shift_q))
        else $error("stuffed zero was not removed");

    a_rx_flag_kept: assert property (@(posedge ref_clk) disable iff (rst)
        (rx_bit_valid && !rx_bit && rx_ones_q == 3'h6)
        |=> rx_cnt_q == $past(rx_cnt_q) + 3'h1)
        else $error("zero after six ones was dropped");

    a_rx_lsb_first: assert property (@(posedge ref_clk) disable iff (rst)
        rx_done |=> rx_byte_q[7] == $past(rx_bit) && rx_byte_q[0] == $past(rx_shift_q[1]))
        else $error("receive byte bit order wrong");

    a_rx_match_set: assert property (@(posedge ref_clk) disable iff (rst)
        (rx_done && rx_new == match1_q) |=> status_q[`LFB_ST_MATCH])
        else $error("match flag missing");

    a_tx_empty_set: assert property (@(posedge ref_clk) disable iff (rst)
        tx_last |=> status_q[`LFB_ST_TX_EMPTY] && tx_bit == $past(tx_shift_q[0]))
        else $error("transmit empty flag missing");

    a_tx_stuff_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (tx_bit_req && tx_state_q == lfb_pkg::LFB_TX_SEND && tx_stuff)
        |=> !tx_bit && $stable(tx_cnt_q))
        else $error("no zero stuffed after five ones");

    a_tx_mf_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (tx_state_q == lfb_pkg::LFB_TX_WAIT && !tx_mf_boundary && ctrl_q[`LFB_CTRL_MF_LOAD])
        |=> tx_state_q == lfb_pkg::LFB_TX_WAIT)
        else $error("transmit byte loaded off the multiframe boundary");

    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        (status_q[`LFB_ST_RX_FULL] && !flag_clr[`LFB_ST_RX_FULL])
        |=> status_q[`LFB_ST_RX_FULL])
        else $error("receive full flag dropped without a clear");

    a_int_level: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 (int_n == ~|($past(status_d) & $past(mask_q))))
        else $error("interrupt level disagrees with flags");

    // reloads read the host copy, so a byte left unwritten simply goes out again
    a_tx_reload_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (tx_state_q == lfb_pkg::LFB_TX_LOAD && !rst)
        |=> tx_shift_q == $past(tx_hold_q) && tx_state_q == lfb_pkg::LFB_TX_SEND)
        else $error("transmit byte not reloaded from the host copy");

    a_tx_one_per_req: assert property (@(posedge ref_clk) disable iff (rst)
        (tx_bit_req && tx_state_q == lfb_pkg::LFB_TX_SEND && !tx_stuff)
        |=> tx_cnt_q == $past(tx_cnt_q) + 3'h1 && tx_bit == $past(tx_shift_q[0]))
        else $error("transmit bit not taken from the low end");

    a_tx_wait_frozen: assert property (@(posedge ref_clk) disable iff (rst)
        tx_state_q == lfb_pkg::LFB_TX_WAIT
        |=> $stable(tx_bit) && $stable(tx_shift_q))
        else $error("transmit shifter moved while waiting for the multiframe");

    a_rx_idle_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !rx_bit_valid |=> $stable(rx_cnt_q) && $stable(rx_shift_q))
        else $error("receive shifter moved without a link bit");

    a_rx_match_two: assert property (@(posedge ref_clk) disable iff (rst)
        (rx_done && rx_new == match2_q) |=> status_q[`LFB_ST_MATCH])
        else $error("second match byte not flagged");

    a_flag_cleared: assert property (@(posedge ref_clk) disable iff (rst)
        (flag_clr[`LFB_ST_RX_FULL] && !flag_set[`LFB_ST_RX_FULL])
        |=> !status_q[`LFB_ST_RX_FULL])
        else $error("receive full flag survived a clear");

    a_int_masked: assert property (@(posedge ref_clk) disable iff (rst)
        (mask_q == 3'h0) |=> int_n)
        else $error("interrupt raised with every source masked");

    c_rx_byte: cover property (@(posedge ref_clk) disable iff (rst)
        rx_done && flag_set[`LFB_ST_MATCH]);
    c_rx_destuff: cover property (@(posedge ref_clk) disable iff (rst)
        rx_bit_valid && rx_drop);
    c_tx_stuff: cover property (@(posedge ref_clk) disable iff (rst)
        tx_bit_req && tx_stuff && tx_state_q == lfb_pkg::LFB_TX_SEND);
    c_clear_race: cover property (@(posedge ref_clk) disable iff (rst)
        rx_done && flag_clr[`LFB_ST_RX_FULL]);
    c_tx_mf_wait: cover property (@(posedge ref_clk) disable iff (rst)
        tx_state_q == lfb_pkg::LFB_TX_WAIT && tx_mf_boundary);

endmodule

/* sim/lfb_framer_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// framer side: received bit slots every 2 cycles, transmit slots every 4 cycles
module lfb_framer_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        rx_go,
    input  wire logic [15:0] rx_word,
    input  wire logic [4:0]  rx_len,
    input  wire logic        tx_go,
    input  wire logic [4:0]  tx_len,
    input  wire logic        tx_bit,
    output logic             rx_bit_valid,
    output logic             rx_bit,
    output logic             tx_bit_req,
    output logic             busy,
    output logic      [15:0] tx_hist
);
    logic [15:0] rx_sh_q;
    logic [4:0]  rx_left_q;
    logic [4:0]  tx_left_q;
    logic [1:0]  tx_div_q;
    logic        take_q;

    assign busy = (rx_left_q != 5'h00) || (tx_left_q != 5'h00) || rx_bit_valid
                  || tx_bit_req || take_q;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_left_q    <= 5'h00;
            rx_bit_valid <= 1'b0;
            rx_bit       <= 1'b0;
        end else if (rx_go) begin
            rx_sh_q   <= rx_word;
            rx_left_q <= rx_len;
        end else if (rx_left_q != 5'h00 && !rx_bit_valid) begin
            rx_bit_valid <= 1'b1;
            rx_bit       <= rx_sh_q[0];
            rx_sh_q      <= rx_sh_q >> 1;
            rx_left_q    <= rx_left_q - 5'h01;
        end else begin
            // toggles outside a slot so a stale bit can never be mistaken for data
            rx_bit_valid <= 1'b0;
            rx_bit       <= ~rx_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_left_q  <= 5'h00;
            tx_div_q   <= 2'h0;
            tx_bit_req <= 1'b0;
            take_q     <= 1'b0;
            tx_hist    <= 16'h0000;
        end else begin
            take_q     <= tx_bit_req;
            tx_bit_req <= 1'b0;
            tx_div_q   <= tx_div_q + 2'h1;
            if (tx_go) begin
                tx_left_q <= tx_len;
            end else if (tx_left_q != 5'h00 && tx_div_q == 2'h0) begin
                // four cycles per slot leaves the reload gap after each byte
                tx_bit_req <= 1'b1;
                tx_left_q  <= tx_left_q - 5'h01;
            end
            if (take_q) begin
                tx_hist <= {tx_bit, tx_hist[15:1]};
            end
        end
    end
endmodule

/* sim/legacy_fdl_byte_shifter_tb.sv */
`timescale 1ns/10ps
`include "lfb_consts.svh"
module legacy_fdl_byte_shifter_tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_bit_valid;
    logic        rx_bit;
    logic        tx_bit_req;
    logic        tx_mf_boundary = 1'b0;
    logic        tx_bit;
    logic        tx_fs_from_shifter;
    logic        int_n;
    logic        rx_go = 1'b0;
    logic        tx_go = 1'b0;
    logic [15:0] rx_word = 16'h0000;
    logic [4:0]  rx_len = 5'h00;
    logic        busy;
    logic [15:0] tx_hist;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    always #2.5 ref_clk = ~ref_clk;

    lfb_link_shifter #(.BYTE_PERIOD_CYC(64)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .tx_bit_req(tx_bit_req), .tx_mf_boundary(tx_mf_boundary), .tx_bit(tx_bit),
        .tx_fs_from_shifter(tx_fs_from_shifter), .int_n(int_n));

    lfb_framer_model framer (.ref_clk(ref_clk), .rst(rst), .rx_go(rx_go), .rx_word(rx_word),
        .rx_len(rx_len), .tx_go(tx_go), .tx_len(rx_len), .tx_bit(tx_bit),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .tx_bit_req(tx_bit_req), .busy(busy),
        .tx_hist(tx_hist));

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        // all scenarios finish well inside this many cycles
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", {31'h0, pready}, 32'h1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, ad(idx), d, r, e);
    endtask

    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp,
                      input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(what, r, exp);
        check("slave_error", {31'h0, e}, {31'h0, exp_err});
    endtask

    // one framer burst: n received bits of w, or n transmit slots
    task automatic link(input logic is_rx, input logic [15:0] w, input logic [4:0] n);
        int k;
        k = 0;
        @(posedge ref_clk);
        rx_word <= w;
        rx_len  <= n;
        rx_go   <= is_rx;
        tx_go   <= !is_rx;
        @(posedge ref_clk);
        rx_go   <= 1'b0;
        tx_go   <= 1'b0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (busy !== 1'b0 && k < 400);
        check("link_idle", {31'h0, busy}, 32'h0);
        repeat (3) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] regs [7] = '{`LFB_IDX_RX_BYTE, `LFB_IDX_RX_MATCH1, `LFB_IDX_RX_MATCH2,
                                 `LFB_IDX_TX_BYTE, `LFB_IDX_CTRL, `LFB_IDX_STATUS, `LFB_IDX_MASK};
        foreach (regs[i]) rd("reset_value", ad(regs[i]), 32'h0, 1'b0);
        wr(`LFB_IDX_RX_BYTE, 32'h55);
        rd("rx_byte_ro", ad(`LFB_IDX_RX_BYTE), 32'h0, 1'b0);
        wr(`LFB_IDX_CTRL, 32'hF);
        rd("ctrl_rw", ad(`LFB_IDX_CTRL), 32'hF, 1'b0);
        rd("misaligned", 12'h201, 32'h0, 1'b1);
        wr(`LFB_IDX_CTRL, 32'h0);
        rd("unmapped", 12'h0C0, 32'h0, 1'b1);
    endtask

    task automatic t_rx();
        wr(`LFB_IDX_MASK, 32'h7);
        wr(`LFB_IDX_RX_MATCH1, 32'hA5);
        wr(`LFB_IDX_RX_MATCH2, 32'h3C);
        link(1'b1, 16'h00A5, 5'd8);
        rd("rx_byte", ad(`LFB_IDX_RX_BYTE), 32'hA5, 1'b0);
        rd("status_full_match", ad(`LFB_IDX_STATUS), 32'h5, 1'b0);
        check("int_n_low", {31'h0, int_n}, 32'h0);
        wr(`LFB_IDX_STATUS, 32'h7);
        repeat (2) @(posedge ref_clk);
        check("int_n_cleared", {31'h0, int_n}, 32'h1);
        link(1'b1, 16'h003C, 5'd8);
        rd("status_match_two", ad(`LFB_IDX_STATUS), 32'h5, 1'b0);
        wr(`LFB_IDX_STATUS, 32'h7);
        wr(`LFB_IDX_MASK, 32'h0);
        link(1'b1, 16'h0011, 5'd8);
        rd("status_no_match", ad(`LFB_IDX_STATUS), 32'h4, 1'b0);
        check("int_n_masked", {31'h0, int_n}, 32'h1);
        wr(`LFB_IDX_MASK, 32'h4);
        repeat (2) @(posedge ref_clk);
        check("int_n_unmasked", {31'h0, int_n}, 32'h0);
        wr(`LFB_IDX_STATUS, 32'h7);
    endtask

    task automatic t_destuff();
        wr(`LFB_IDX_CTRL, 32'h1);
        link(1'b1, 16'h009F, 5'd9);
        rd("destuffed", ad(`LFB_IDX_RX_BYTE), 32'h5F, 1'b0);
        link(1'b1, 16'h00BF, 5'd8);
        rd("six_ones_kept", ad(`LFB_IDX_RX_BYTE), 32'hBF, 1'b0);
        wr(`LFB_IDX_STATUS, 32'h7);
    endtask

    task automatic t_tx();
        wr(`LFB_IDX_CTRL, 32'h0);
        wr(`LFB_IDX_MASK, 32'h2);
        wr(`LFB_IDX_TX_BYTE, 32'hB4);
        link(1'b0, 16'h0, 5'd8);
        check("tx_reset_byte", {24'h0, tx_hist[15:8]}, 32'h00);
        rd("status_empty", ad(`LFB_IDX_STATUS), 32'h2, 1'b0);
        check("int_n_empty", {31'h0, int_n}, 32'h0);
        wr(`LFB_IDX_STATUS, 32'h7);
        link(1'b0, 16'h0, 5'd8);
        check("tx_lsb_first", {24'h0, tx_hist[15:8]}, 32'hB4);
        wr(`LFB_IDX_TX_BYTE, 32'h00);
        link(1'b0, 16'h0, 5'd8);
        check("tx_resent", {24'h0, tx_hist[15:8]}, 32'hB4);
        wr(`LFB_IDX_TX_BYTE, 32'hFF);
        link(1'b0, 16'h0, 5'd8);
        check("tx_zero_byte", {24'h0, tx_hist[15:8]}, 32'h00);
        wr(`LFB_IDX_CTRL, 32'h3);
        link(1'b0, 16'h0, 5'd9);
        check("tx_stuffed", {23'h0, tx_hist[15:7]}, 32'h1DF);
    endtask

    task automatic t_mf();
        wr(`LFB_IDX_CTRL, 32'h4);
        @(posedge ref_clk);
        check("fs_from_shifter", {31'h0, tx_fs_from_shifter}, 32'h1);
        wr(`LFB_IDX_TX_BYTE, 32'h1C);
        link(1'b0, 16'h0, 5'd8);
        check("tx_before_wait", {24'h0, tx_hist[15:8]}, 32'hFF);
        link(1'b0, 16'h0, 5'd8);
        check("tx_held_for_mf", {24'h0, tx_hist[15:8]}, 32'hFF);
        @(posedge ref_clk);
        tx_mf_boundary <= 1'b1;
        @(posedge ref_clk);
        tx_mf_boundary <= 1'b0;
        repeat (2) @(posedge ref_clk);
        link(1'b0, 16'h0, 5'd8);
        check("tx_fs_pattern", {24'h0, tx_hist[15:8]}, 32'h1C);
        wr(`LFB_IDX_CTRL, 32'h8);
        @(posedge ref_clk);
        check("fs_from_elsewhere", {31'h0, tx_fs_from_shifter}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_rx();
        t_destuff();
        t_tx();
        t_mf();
        report_and_stop();
    end
endmodule
